// [rtl/ccpu_pkg.sv]
`default_nettype none
package ccpu_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_CONTROL = 8'h00;
   localparam logic [7:0] OFS_CAPSEL  = 8'h04;
   localparam logic [7:0] OFS_VALLO   = 8'h08;
   localparam logic [7:0] OFS_VALHI   = 8'h0C;
   // register word indices (address bits 3:2)
   localparam logic [1:0] IDX_CONTROL = 2'h0;
   localparam logic [1:0] IDX_CAPSEL  = 2'h1;
   localparam logic [1:0] IDX_VALLO   = 2'h2;
   localparam logic [1:0] IDX_VALHI   = 2'h3;
   // control field positions
   localparam int CTL_EN_BIT   = 7;
   localparam int CTL_OUT_BIT  = 5;
   localparam int CTL_FMT_BIT  = 4;
   localparam int CTL_MODE_LSB = 0;
   localparam int CTL_MODE_MSB = 3;
   localparam int CAP_SEL_MSB  = 2;
   // mode codes
   localparam logic [3:0] MODE_OFF       = 4'h0;
   localparam logic [3:0] MODE_TOGCLR    = 4'h1;
   localparam logic [3:0] MODE_TOGGLE    = 4'h2;
   localparam logic [3:0] MODE_CAPBOTH   = 4'h3;
   localparam logic [3:0] MODE_CAPFALL   = 4'h4;
   localparam logic [3:0] MODE_CAPRISE   = 4'h5;
   localparam logic [3:0] MODE_CAPRISE4  = 4'h6;
   localparam logic [3:0] MODE_CAPRISE16 = 4'h7;
   localparam logic [3:0] MODE_SET       = 4'h8;
   localparam logic [3:0] MODE_CLEAR     = 4'h9;
   localparam logic [3:0] MODE_PULSE     = 4'hA;
   localparam logic [3:0] MODE_PULSECLR  = 4'hB;
   localparam logic [1:0] MODE_PWM_TOP   = 2'h3;
   // capture source codes
   localparam logic [2:0] SRC_PIN   = 3'h0;
   localparam logic [2:0] SRC_CMP1  = 3'h1;
   localparam logic [2:0] SRC_CMP2  = 3'h2;
   localparam logic [2:0] SRC_PCHG  = 3'h3;
   // prescaled capture counts
   localparam logic [3:0] PRESC4_LAST  = 4'h3;
   localparam logic [3:0] PRESC16_LAST = 4'hF;
   // reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [9:0] RST_DUTY = 10'h000;
   // axi responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [15:0] sixteenBitTimer;
      logic [7:0]  periodTimer;
      logic [7:0]  periodValue;
      logic [1:0]  timeBaseExt;
      logic        periodTimerInc;
   } ccpu_timer_s;

   typedef struct packed {
      logic       mappedInputPin;
      logic       firstComparatorOutput;
      logic       secondComparatorOutput;
      logic       pinChangeInterrupt;
      logic [3:0] logicCellOutput;
   } ccpu_capin_s;

   typedef struct packed {
      logic       en;
      logic       dutyAlignment;
      logic [3:0] mode;
      logic [2:0] capSel;
      logic [7:0] valLo;
      logic [7:0] valHi;
      logic       outLevel;
      logic       pinOe;
      logic       prevIn;
      logic [3:0] edgeCnt;
      logic [9:0] dutyBuf;
      logic       pulseOn;
      logic       matchPrev;
      logic       evt;
      logic       clr16;
      logic       clrPer;
      logic       awHave;
      logic       awOk;
      logic [1:0] awIdx;
      logic       wHave;
      logic [7:0] wByte;
      logic       wLane;
      logic       bvalid;
      logic [1:0] bresp;
      logic       rvalid;
      logic [1:0] rresp;
      logic [7:0] rdata;
   } ccpu_state_s;
endpackage
`default_nettype wire

// [rtl/ccpu_unit.sv]
// Decided for this implementation: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module ccpu_unit
   import ccpu_pkg::*;
#(
   parameter int ADDR_W = 8
)(
   input  wire logic              core_clk,
   input  wire logic              nrst,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   input  wire ccpu_timer_s       timers,
   input  wire ccpu_capin_s       captureInputs,
   input  wire logic              adcTriggerSelect,
   output logic                   unitPin,
   output logic                   unitPinOe,
   output logic                   unitEventFlag,
   output logic                   adcTrigger,
   output logic                   sixteenBitTimerClear,
   output logic                   periodTimerClear
);

   logic [1:0]  rstSync;
   logic        rstN;
   ccpu_state_s stateReg;
   ccpu_state_s stateNext;
   logic        selIn;
   logic        rise;
   logic        fall;
   logic        isPwm;
   logic        isCapture;
   logic        isCompare;
   logic        running;
   logic        captureNow;
   logic        match;
   logic        hit;
   logic [9:0]  duty;
   logic [9:0]  timeBase;
   logic        periodHit;
   logic [7:0]  rdByte;
   logic [1:0]  arIdx;
   logic        arOk;

   // reset release through two flops
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rstSync <= 2'b00;
      end else begin
         rstSync <= {rstSync[0], 1'b1};
      end
   end
   assign rstN = rstSync[1];

   always_comb begin
      unique case (stateReg.capSel)
         SRC_PIN:  selIn = captureInputs.mappedInputPin;
         SRC_CMP1: selIn = captureInputs.firstComparatorOutput;
         SRC_CMP2: selIn = captureInputs.secondComparatorOutput;
         SRC_PCHG: selIn = captureInputs.pinChangeInterrupt;
         default:  selIn = captureInputs.logicCellOutput[stateReg.capSel[1:0]];
      endcase
   end

   assign rise = selIn & ~stateReg.prevIn;
   assign fall = ~selIn & stateReg.prevIn;

   assign isPwm     = (stateReg.mode[3:2] == MODE_PWM_TOP);
   assign isCapture = (stateReg.mode >= MODE_CAPBOTH)
                    && (stateReg.mode <= MODE_CAPRISE16);
   assign isCompare = !isPwm && !isCapture && (stateReg.mode != MODE_OFF);
   assign running   = stateReg.en && (stateReg.mode != MODE_OFF);

   assign match = ({stateReg.valHi, stateReg.valLo}
                   == timers.sixteenBitTimer);
   assign hit   = running && isCompare && match && !stateReg.matchPrev;

   always_comb begin
      if (stateReg.dutyAlignment) begin
         duty = {stateReg.valHi, stateReg.valLo[7:6]};
      end else begin
         duty = {stateReg.valHi[1:0], stateReg.valLo};
      end
   end

   assign timeBase  = {timers.periodTimer, timers.timeBaseExt};
   assign periodHit = running && isPwm && timers.periodTimerInc
                    && (timers.periodTimer == timers.periodValue);

   always_comb begin
      captureNow = 1'b0;
      if (running && isCapture) begin
         unique case (stateReg.mode)
            MODE_CAPBOTH:   captureNow = rise | fall;
            MODE_CAPFALL:   captureNow = fall;
            MODE_CAPRISE:   captureNow = rise;
            MODE_CAPRISE4:  captureNow = rise
                               && (stateReg.edgeCnt[1:0] == PRESC4_LAST[1:0]);
            MODE_CAPRISE16: captureNow = rise
                               && (stateReg.edgeCnt == PRESC16_LAST);
            default:        captureNow = 1'b0;
         endcase
      end
   end

   // read mux with zero unused bits
   always_comb begin
      unique case (arIdx)
         IDX_CONTROL: rdByte = {stateReg.en, 1'b0, stateReg.outLevel,
                                stateReg.dutyAlignment, stateReg.mode};
         IDX_CAPSEL:  rdByte = {5'h00, stateReg.capSel};
         IDX_VALLO:   rdByte = stateReg.valLo;
         IDX_VALHI:   rdByte = stateReg.valHi;
      endcase
   end
   assign arIdx = s_axi_araddr[3:2];
   assign arOk  = (s_axi_araddr[ADDR_W-1:4] == '0)
                && (s_axi_araddr[1:0] == 2'b00);

   always_comb begin
      stateNext        = stateReg;
      stateNext.evt    = 1'b0;
      stateNext.clr16  = 1'b0;
      stateNext.clrPer = 1'b0;
      stateNext.prevIn = selIn;

      if (!running) begin
         stateNext.outLevel  = 1'b0;
         stateNext.edgeCnt   = 4'h0;
         stateNext.pulseOn   = 1'b0;
         stateNext.matchPrev = 1'b0;
         stateNext.dutyBuf   = RST_DUTY;
      end else if (isCapture) begin
         if (rise && (stateReg.mode == MODE_CAPRISE4
                      || stateReg.mode == MODE_CAPRISE16)) begin
            stateNext.edgeCnt = captureNow ? 4'h0 : stateReg.edgeCnt + 4'h1;
         end
         if (captureNow) begin
            stateNext.valLo = timers.sixteenBitTimer[7:0];
            stateNext.valHi = timers.sixteenBitTimer[15:8];
            stateNext.evt   = 1'b1;
         end
      end else if (isCompare) begin
         stateNext.matchPrev = match;
         if (stateReg.pulseOn) begin
            stateNext.outLevel = 1'b0;
            stateNext.pulseOn  = 1'b0;
         end
         if (hit) begin
            stateNext.evt = 1'b1;
            unique case (stateReg.mode)
               MODE_TOGCLR: begin
                  stateNext.outLevel = ~stateReg.outLevel;
                  stateNext.clr16    = 1'b1;
               end
               MODE_TOGGLE: stateNext.outLevel = ~stateReg.outLevel;
               MODE_SET:    stateNext.outLevel = 1'b1;
               MODE_CLEAR:  stateNext.outLevel = 1'b0;
               MODE_PULSECLR: begin
                  stateNext.outLevel = 1'b1;
                  stateNext.pulseOn  = 1'b1;
                  stateNext.clr16    = 1'b1;
               end
               MODE_PULSE: begin
                  stateNext.outLevel = 1'b1;
                  stateNext.pulseOn  = 1'b1;
               end
               default: stateNext.outLevel = stateReg.outLevel;
            endcase
         end
      end else begin
         if (periodHit) begin
            stateNext.clrPer   = 1'b1;
            stateNext.dutyBuf  = duty;
            stateNext.outLevel = (duty != RST_DUTY);
            stateNext.evt      = 1'b1;
         end else if (timeBase == stateReg.dutyBuf) begin
            stateNext.outLevel = 1'b0;
         end
      end

      stateNext.pinOe = stateReg.en && (isCompare || isPwm);

      // axi write address and data, either order
      if (s_axi_awvalid && s_axi_awready) begin
         stateNext.awHave = 1'b1;
         stateNext.awIdx  = s_axi_awaddr[3:2];
         stateNext.awOk   = (s_axi_awaddr[ADDR_W-1:4] == '0)
                          && (s_axi_awaddr[1:0] == 2'b00);
      end
      if (s_axi_wvalid && s_axi_wready) begin
         stateNext.wHave = 1'b1;
         stateNext.wByte = s_axi_wdata[7:0];
         stateNext.wLane = s_axi_wstrb[0];
      end
      if (stateReg.awHave && stateReg.wHave) begin
         stateNext.awHave = 1'b0;
         stateNext.wHave  = 1'b0;
         stateNext.bvalid = 1'b1;
         stateNext.bresp  = stateReg.awOk ? RESP_OKAY : RESP_SLVERR;
         if (stateReg.awOk && stateReg.wLane) begin
            unique case (stateReg.awIdx)
               IDX_CONTROL: begin
                  stateNext.en            = stateReg.wByte[CTL_EN_BIT];
                  stateNext.dutyAlignment = stateReg.wByte[CTL_FMT_BIT];
                  stateNext.mode =
                     stateReg.wByte[CTL_MODE_MSB:CTL_MODE_LSB];
                  if (stateNext.mode != stateReg.mode) begin
                     stateNext.edgeCnt = 4'h0;
                  end
               end
               IDX_CAPSEL: stateNext.capSel = stateReg.wByte[CAP_SEL_MSB:0];
               IDX_VALLO: begin
                  if (!captureNow) begin
                     stateNext.valLo = stateReg.wByte;
                  end
               end
               IDX_VALHI: begin
                  if (!captureNow) begin
                     stateNext.valHi = stateReg.wByte;
                  end
               end
            endcase
         end
      end
      if (stateReg.bvalid && s_axi_bready) begin
         stateNext.bvalid = 1'b0;
      end

      // axi read
      if (s_axi_arvalid && s_axi_arready) begin
         stateNext.rvalid = 1'b1;
         stateNext.rdata  = arOk ? rdByte : RST_BYTE;
         stateNext.rresp  = arOk ? RESP_OKAY : RESP_SLVERR;
      end else if (stateReg.rvalid && s_axi_rready) begin
         stateNext.rvalid = 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         stateReg <= '0;
      end else begin
         stateReg <= stateNext;
      end
   end

   assign s_axi_awready = !stateReg.awHave && !stateReg.bvalid;
   assign s_axi_wready  = !stateReg.wHave && !stateReg.bvalid;
   assign s_axi_bvalid  = stateReg.bvalid;
   assign s_axi_bresp   = stateReg.bresp;
   assign s_axi_arready = !stateReg.rvalid;
   assign s_axi_rvalid  = stateReg.rvalid;
   assign s_axi_rresp   = stateReg.rresp;
   assign s_axi_rdata   = {24'h000000, stateReg.rdata};

   assign unitPin              = stateReg.outLevel;
   assign unitPinOe            = stateReg.pinOe;
   assign unitEventFlag        = stateReg.evt;
   assign adcTrigger           = stateReg.evt & adcTriggerSelect;
   assign sixteenBitTimerClear = stateReg.clr16;
   assign periodTimerClear     = stateReg.clrPer;

endmodule
`default_nettype wire

// [bench/ccpu_far_side.sv]
`timescale 1ns/100ps
`default_nettype none
module ccpu_far_side
   import ccpu_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       nrst,
   input  wire logic [7:0] periodValue,
   input  wire logic       sixteenBitTimerClear,
   input  wire logic       periodTimerClear,
   output var ccpu_timer_s timers
);
   // free running timers, cleared on the unit's request
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         timers <= '0;
      end else begin
         timers.periodValue <= periodValue;
         timers.timeBaseExt <= timers.timeBaseExt + 2'h1;
         timers.periodTimerInc <= timers.timeBaseExt == 2'h2;
         timers.sixteenBitTimer <= sixteenBitTimerClear ? 16'h0000
            : timers.sixteenBitTimer + 16'h0001;
         if (periodTimerClear) begin
            timers.periodTimer <= 8'h00;
         end else if (timers.periodTimerInc) begin
            timers.periodTimer <= (timers.periodTimer == periodValue) ? 8'h00
               : timers.periodTimer + 8'h01;
         end
      end
   end
endmodule
`default_nettype wire

// [bench/ccpu_unit_properties.sv]
`timescale 1ns/100ps
`default_nettype none
module ccpu_unit_properties
   import ccpu_pkg::*;
#(
   parameter int ADDR_W = 8
)(
   input wire logic              core_clk,
   input wire logic              nrst,
   input wire logic              s_axi_awvalid,
   input wire logic              s_axi_awready,
   input wire logic              s_axi_wvalid,
   input wire logic              s_axi_wready,
   input wire logic              s_axi_bvalid,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic              s_axi_arvalid,
   input wire logic              s_axi_arready,
   input wire logic [1:0]        s_axi_rresp,
   input wire logic              s_axi_rvalid,
   input wire ccpu_timer_s       timers,
   input wire logic              adcTriggerSelect,
   input wire logic              unitPin,
   input wire logic              unitPinOe,
   input wire logic              unitEventFlag,
   input wire logic              adcTrigger,
   input wire logic              sixteenBitTimerClear,
   input wire logic              periodTimerClear
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   write_answer_a: assert property (wr_taken |-> ##2 s_axi_bvalid)
      else $error("write response late");
   read_answer_a: assert property (rd_taken |=> s_axi_rvalid)
      else $error("read response late");
   bad_read_a: assert property ((rd_taken ##0 s_axi_araddr[1:0] != 2'h0)
      |=> s_axi_rresp == RESP_SLVERR) else $error("misaligned read accepted");
   adc_follow_a:
      assert property (adcTrigger == (unitEventFlag && adcTriggerSelect))
      else $error("converter trigger wrong");
   clear_event_a:
      assert property (sixteenBitTimerClear |-> unitEventFlag)
      else $error("timer clear without event");
   wrap_cause_a:
      assert property (periodTimerClear |-> $past(timers.periodTimerInc)
         && $past(timers.periodTimer) == $past(timers.periodValue))
      else $error("period clear without period match");
   wrap_event_a:
      assert property (periodTimerClear |-> unitEventFlag && unitPinOe)
      else $error("period clear without event or drive");
   reset_quiet_a:
      assert property (disable iff (1'b0)
         !nrst |-> !unitPinOe && !unitPin && !unitEventFlag)
      else $error("outputs active in reset");
endmodule
bind ccpu_unit ccpu_unit_properties #(.ADDR_W(ADDR_W)) u_props (.core_clk,
   .nrst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rresp, .s_axi_rvalid, .timers, .adcTriggerSelect, .unitPin,
   .unitPinOe, .unitEventFlag, .adcTrigger, .sixteenBitTimerClear,
   .periodTimerClear);
`default_nettype wire

// [bench/capture_compare_pwm_unit_bench.sv]
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, s) begin n_checks++; if ((s) !== (e)) begin n_errors++; \
   $display("BAD %s exp %0h got %0h", nm, e, s); end end
`define WAIT(c) begin int k; k = 0; @(negedge core_clk); \
   while (!(c)) begin k++; if (k > 3000) print_verdict(1); \
   @(negedge core_clk); end end
module capture_compare_pwm_unit_bench
   import ccpu_pkg::*;
;
   logic        core_clk = 1'b0, nrst = 1'b1, capLvl = 1'b0, ep;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, v;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rval;
   logic [3:0]  s_axi_wstrb = 4'hF, m;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
   logic        s_axi_rready = 1'b0, adcTriggerSelect = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic        s_axi_rvalid, unitPin, unitPinOe, unitEventFlag, adcTrigger;
   logic        sixteenBitTimerClear, periodTimerClear;
   logic [1:0]  s_axi_bresp, s_axi_rresp, wresp, rrsp;
   logic [31:0] rnd = 32'h43151CD9;
   logic [15:0] capVal, t;
   logic [9:0]  d;
   logic [7:0]  periodValue = 8'h07;
   logic [2:0]  capSel = 3'h0;
   ccpu_timer_s timers;
   ccpu_capin_s captureInputs = '0;
   int          n_errors = 0, n_checks = 0, nFlag = 0, h;
   logic [7:0]  capCtl[6] = '{8'h85, 8'h84, 8'h83, 8'h86, 8'h87, 8'h05};
   int          capN[6] = '{16, 16, 32, 4, 1, 0};
   logic [3:0]  cmpM[6] = '{4'h8, 4'h9, 4'h2, 4'h1, 4'hA, 4'hB};
   logic [7:0]  pwmCtl[3] = '{8'h8F, 8'h9C, 8'h9F};
   logic [9:0]  pwmD[3] = '{10'h00D, 10'h015, 10'h000};

   ccpu_unit u_dut (.core_clk, .nrst, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .timers, .captureInputs, .adcTriggerSelect, .unitPin, .unitPinOe,
      .unitEventFlag, .adcTrigger, .sixteenBitTimerClear, .periodTimerClear);
   ccpu_far_side u_far (.core_clk, .nrst, .periodValue, .sixteenBitTimerClear,
      .periodTimerClear, .timers);

   function automatic logic [31:0] lfsr(input logic [31:0] r);
      return {r[30:0], r[31] ^ r[21] ^ r[1] ^ r[0]};
   endfunction
   // selected line follows capLvl, all others random
   function automatic ccpu_capin_s mix(input logic [7:0] r,
      input logic [2:0] s, input logic l);
      r[(s < 3'h4) ? 3'h7 - s : s - 3'h4] = l;
      return ccpu_capin_s'(r);
   endfunction

   always #25 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      rnd <= lfsr(rnd);
      captureInputs <= mix(rnd[7:0], capSel, capLvl);
      adcTriggerSelect <= rnd[9];
   end
   always @(negedge core_clk) begin
      if (unitEventFlag === 1'b1) begin
         nFlag++;
         capVal = timers.sixteenBitTimer - 16'h0001;
      end
   end

   task automatic print_verdict(input int bad);
      n_errors += bad;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic do_reset;
      nrst <= 1'b0;
      repeat (10) @(posedge core_clk);
      nrst <= 1'b1;
      repeat (3) @(posedge core_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] dv);
      logic awOpen, wOpen, awTake, wTake;
      int   tries;
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h000000, dv};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      awOpen = 1'b1;
      wOpen = 1'b1;
      tries = 0;
      // each channel is released at the edge that takes it
      while (awOpen || wOpen) begin
         @(negedge core_clk);
         tries++;
         if (tries > 3000) print_verdict(1);
         awTake = awOpen && s_axi_awready;
         wTake = wOpen && s_axi_wready;
         @(posedge core_clk);
         if (awTake) begin
            s_axi_awvalid <= 1'b0;
            awOpen = 1'b0;
         end
         if (wTake) begin
            s_axi_wvalid <= 1'b0;
            wOpen = 1'b0;
         end
      end
      `WAIT(s_axi_bvalid)
      wresp = s_axi_bresp;
      @(posedge core_clk);
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge core_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      `WAIT(s_axi_arready)
      @(posedge core_clk);
      s_axi_arvalid <= 1'b0;
      `WAIT(s_axi_rvalid)
      rval = s_axi_rdata;
      rrsp = s_axi_rresp;
      @(posedge core_clk);
      s_axi_rready <= 1'b0;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      rd(a);
      `CHK("rdata", {24'h000000, e}, rval)
   endtask

   initial begin
      do_reset;
      for (int i = 0; i < 4; i++) rdchk({i[5:0], 2'b00}, 8'h00);
      rd(8'h12);
      `CHK("rresp", RESP_SLVERR, rrsp)
      wr(8'h30, 8'h55);
      `CHK("bresp", RESP_SLVERR, wresp)
      wr(OFS_CONTROL, 8'h7F);
      rdchk(OFS_CONTROL, 8'h1F);
      wr(OFS_CAPSEL, 8'hFF);
      rdchk(OFS_CAPSEL, 8'h07);
      // low byte lane off: answered, nothing written
      s_axi_wstrb <= 4'hE;
      wr(OFS_VALLO, 8'h5A);
      `CHK("bresp", RESP_OKAY, wresp)
      s_axi_wstrb <= 4'hF;
      rdchk(OFS_VALLO, 8'h00);
      ep = 1'b0;
      foreach (cmpM[i]) begin
         m = cmpM[i];
         t = timers.sixteenBitTimer + 16'h0258;
         wr(OFS_VALHI, t[15:8]);
         wr(OFS_VALLO, t[7:0]);
         v = {3'b100, rnd[0], m};
         wr(OFS_CONTROL, v);
         `WAIT(unitEventFlag)
         ep = (m == 4'h8) | (m[3:1] == 3'h5) | ((m == 4'h2 || m == 4'h1) & ~ep);
         `CHK("pin", ep, unitPin)
         `CHK("clr", m == 4'h1 || m == 4'hB, sixteenBitTimerClear)
         `CHK("tmr", t + 16'h0001, timers.sixteenBitTimer)
         `CHK("oe", 1'b1, unitPinOe)
         if (m[3:1] == 3'h5) begin
            @(negedge core_clk);
            `CHK("pulse", 1'b0, unitPin)
            ep = 1'b0;
         end
         rdchk(OFS_CONTROL, {v[7:6], ep, v[4:0]});
      end
      foreach (capCtl[i]) begin
         v = {5'h00, rnd[2:0]};
         capSel <= v[2:0];
         wr(OFS_CAPSEL, v);
         wr(OFS_CONTROL, capCtl[i]);
         repeat (5) @(posedge core_clk);
         nFlag = 0;
         repeat (16) begin
            capLvl <= 1'b1;
            repeat (4) @(posedge core_clk);
            capLvl <= 1'b0;
            repeat (4) @(posedge core_clk);
         end
         repeat (4) @(posedge core_clk);
         `CHK("caps", capN[i], nFlag)
         if (capN[i] > 0) begin
            rd(OFS_VALHI);
            v = rval[7:0];
            rd(OFS_VALLO);
            `CHK("capv", capVal, {v, rval[7:0]})
         end
      end
      `CHK("dis", 1'b0, unitPinOe | unitPin)
      foreach (pwmCtl[i]) begin
         d = pwmD[i];
         if (pwmCtl[i][4]) begin
            wr(OFS_VALHI, d[9:2]);
            wr(OFS_VALLO, {d[1:0], rnd[5:0]});
         end else begin
            wr(OFS_VALHI, {rnd[7:2], d[9:8]});
            wr(OFS_VALLO, d[7:0]);
         end
         wr(OFS_CONTROL, pwmCtl[i]);
         repeat (80) @(posedge core_clk);
         `WAIT(periodTimerClear)
         h = 0;
         repeat (32) begin
            h += int'(unitPin === 1'b1);
            @(negedge core_clk);
         end
         `CHK("high", (d == 10'h000) ? 0 : int'(d) + 1, h)
      end
      wr(OFS_CONTROL, 8'h80);
      repeat (3) @(posedge core_clk);
      nFlag = 0;
      repeat (40) @(posedge core_clk);
      `CHK("offev", 0, nFlag)
      `CHK("offpin", 1'b0, unitPin)
      wr(OFS_VALLO, 8'hA5);
      do_reset;
      rdchk(OFS_VALLO, 8'h00);
      print_verdict(0);
   end
endmodule
`default_nettype wire
